// ===== hdl/clock_synth_pkg.sv
package clock_synth_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [11:0] CTL_OFFSET        = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFFSET   = 12'h008;

  // clock_synth_control field positions
  localparam int GAIN_BIT      = 15;
  localparam int PRESCALE_BIT  = 14;
  localparam int MOD_LSB       = 8;
  localparam int MOD_W         = 6;
  localparam int DIVIDE_BIT    = 7;
  localparam int LIMP_BIT      = 4;
  localparam int LOCK_BIT      = 3;
  localparam int LOSS_RST_BIT  = 2;
  localparam int STOP_MOD_BIT  = 1;
  localparam int STOP_OUT_BIT  = 0;

  // reset value and the bits that software may write
  localparam logic [15:0] CTL_RESET      = 16'h3F00;
  localparam logic [15:0] CTL_WRITE_MASK = 16'hFF87;

  // interrupt status / mask layout
  localparam int IRQ_W        = 3;
  localparam int IRQ_LOCK_BIT = 0;
  localparam int IRQ_LIMP_BIT = 1;
  localparam int IRQ_LOSS_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // lock delay of the modelled loop
  localparam int unsigned CLOCK_PERIOD_NS  = 50;
  localparam int unsigned LOCK_TIME_NS     = 1000000;
  localparam int unsigned LOCK_CYCLES_DEF  =
    (LOCK_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    clk_acquire,
    clk_running,
    clk_limp
  } clock_state_e;

endpackage : clock_synth_pkg

// ===== hdl/lock_delay_timer.sv
`timescale 1ns/10ps
module lock_delay_timer #(
  parameter int unsigned CYCLES = 20000,
  parameter int          CNT_W  = $clog2(CYCLES + 1)
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  output logic      locked_o
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_locked;

  // a restart or a lost reference throws away progress toward lock
  always_comb begin
    next_count  = count;
    next_locked = locked_o;
    if (!run_i || restart_i) begin
      next_count  = '0;
      next_locked = 1'b0;
    end else if (!locked_o) begin
      if (count == CNT_W'(CYCLES - 1)) begin
        next_locked = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count    <= '0;
      locked_o <= 1'b0;
    end else begin
      count    <= next_count;
      locked_o <= next_locked;
    end
  end

endmodule : lock_delay_timer

// ===== hdl/system_clock_synth_control.sv
`timescale 1ns/10ps
// Notes on behaviour
// - strap high at reset: clock from synthesizer
// - strap low: synthesizer off, external clock
// - synthesizer off: control bits have no effect; here divide bit 7 still drives bus_clock_divide_select_o
// - hold device reset until lock
// - comparator input change forces relock; flag
// - control register reachable only by supervisor
// - prescale bit doubles clock, no relock
// - gain bit quadruples oscillator, needs relock
// - modulus field divides by value plus one
// - clock equals ref times 4(Y+1)2^(2W+X)
// - oscillator is 2x or 4x system clock
// - control register resets to 0x3F00
// - upper byte frequency, lower byte status/control
// - lock flag valid only after first write
// - lost reference sets limp, oscillator keeps running
// - loss-reset enable chooses reset or limp; here limp is entered either way and the bit adds device reset
// - stop selects module clock and output gating
module system_clock_synth_control
  import clock_synth_pkg::*;
#(
  parameter int          ADDR_W      = 12,
  parameter int unsigned LOCK_CYCLES = LOCK_CYCLES_DEF
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic [2:0]        s_axi_awprot_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic [2:0]        s_axi_arprot_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // pins and core signals
  input  wire logic              clock_source_strap_i,
  input  wire logic              reference_present_i,
  input  wire logic              low_power_stop_instr_i,
  output logic                   device_reset_o,
  output logic                   synth_enable_o,
  output logic                   gain_o,
  output logic                   prescale_o,
  output logic [MOD_W-1:0]       feedback_modulus_o,
  output logic [11:0]            system_multiplier_o,
  output logic [12:0]            vco_multiplier_o,
  output logic                   bus_clock_divide_select_o,
  output logic                   oscillator_run_o,
  output logic                   module_clock_from_vco_o,
  output logic                   clock_output_pin_enable_o,
  output logic                   irq_o
);

  // pin synchronisers
  logic [1:0] pin_raw;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_level;
  logic [1:0] next_pin_level;

  assign pin_raw = {reference_present_i, clock_source_strap_i};

  // no reset here: the strap must already be settled while reset is held
  for (genvar g = 0; g < 2; g++) begin : g_pin_sync
    always_comb begin
      next_pin_level[g] = (pin_s2[g] == pin_s3[g]) ? pin_s2[g] : pin_level[g];
    end
    always_ff @(posedge clock_i) begin
      pin_s1[g]    <= pin_raw[g];
      pin_s2[g]    <= pin_s1[g];
      pin_s3[g]    <= pin_s2[g];
      pin_level[g] <= next_pin_level[g];
    end
  end

  logic ref_ok;
  assign ref_ok = pin_level[1];

  // bus slave
  logic              aw_held, next_aw_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic              aw_priv, next_aw_priv;
  logic              w_held, next_w_held;
  logic [15:0]       w_data, next_w_data;
  logic [1:0]        w_strb, next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              wr_fire;
  logic              rd_fire;
  logic              wr_ctl;
  logic              wr_status;
  logic              wr_mask;

  // register state, also read by the mux
  logic                 synth_mode;
  logic [15:0]          ctl;
  logic                 written_once;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  clock_state_e         state;
  logic                 lock_done;
  logic                 lock_flag;
  logic [15:0]          ctl_read;

  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  // user-mode writes to the control word are refused with SLVERR
  assign wr_ctl    = wr_fire && (aw_addr == ADDR_W'(CTL_OFFSET)) && aw_priv;
  assign wr_status = wr_fire && (aw_addr == ADDR_W'(IRQ_STATUS_OFFSET));
  assign wr_mask   = wr_fire && (aw_addr == ADDR_W'(IRQ_MASK_OFFSET));

  // lock and limp are live state, bits 6 and 5 always zero
  assign lock_flag = synth_mode ? (written_once && lock_done) : 1'b1;
  always_comb begin
    ctl_read           = ctl & CTL_WRITE_MASK;
    ctl_read[LOCK_BIT] = lock_flag;
    ctl_read[LIMP_BIT] = (state == clk_limp);
  end

  // address and data are taken in either order, then answered together
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_aw_priv = aw_priv;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid_o;
    next_bresp   = s_axi_bresp_o;
    next_rvalid  = s_axi_rvalid_o;
    next_rdata   = s_axi_rdata_o;
    next_rresp   = s_axi_rresp_o;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
      next_aw_priv = s_axi_awprot_i[0];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i[15:0];
      next_w_strb = s_axi_wstrb_i[1:0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_ctl || wr_status || wr_mask) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0;
      if (s_axi_araddr_i == ADDR_W'(CTL_OFFSET) && s_axi_arprot_i[0]) begin
        next_rdata = {16'h0, ctl_read};
      end else if (s_axi_araddr_i == ADDR_W'(IRQ_STATUS_OFFSET)) begin
        next_rdata = {29'h0, irq_status};
      end else if (s_axi_araddr_i == ADDR_W'(IRQ_MASK_OFFSET)) begin
        next_rdata = {29'h0, irq_mask};
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_held        <= 1'b0;
      aw_addr        <= '0;
      aw_priv        <= 1'b0;
      w_held         <= 1'b0;
      w_data         <= 16'h0;
      w_strb         <= 2'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0;
      s_axi_rresp_o  <= RESP_OKAY;
    end else begin
      aw_held        <= next_aw_held;
      aw_addr        <= next_aw_addr;
      aw_priv        <= next_aw_priv;
      w_held         <= next_w_held;
      w_data         <= next_w_data;
      w_strb         <= next_w_strb;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o  <= next_bresp;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rdata_o  <= next_rdata;
      s_axi_rresp_o  <= next_rresp;
    end
  end

  // clock control
  logic [15:0]          next_ctl;
  logic                 next_synth_mode;
  logic                 next_written_once;
  logic [IRQ_W-1:0]     next_irq_status;
  logic [IRQ_W-1:0]     next_irq_mask;
  logic [IRQ_W-1:0]     events;
  clock_state_e         next_state;
  logic                 next_reset_hold;
  logic                 ref_prev;
  logic                 freq_change;
  logic                 lock_restart;
  logic                 stop_now;
  logic                 gain;
  logic                 prescale;
  logic [MOD_W-1:0]     modulus;
  logic [6:0]           divide_by;
  logic [2:0]           sys_shift;
  logic [2:0]           vco_shift;
  logic [11:0]          next_sys_mult;
  logic [12:0]          next_vco_mult;

  // byte lanes merge into the writable bits only
  always_comb begin
    next_ctl = ctl;
    if (wr_ctl) begin
      if (w_strb[0]) begin
        next_ctl[7:0] = w_data[7:0] & CTL_WRITE_MASK[7:0];
      end
      if (w_strb[1]) begin
        next_ctl[15:8] = w_data[15:8];
      end
    end
  end

  assign gain     = ctl[GAIN_BIT];
  assign prescale = ctl[PRESCALE_BIT];
  assign modulus  = ctl[MOD_LSB +: MOD_W];
  // the prescale bit sits outside the loop, so it never restarts lock
  assign freq_change = wr_ctl && ((next_ctl[GAIN_BIT] != gain) ||
                       (next_ctl[MOD_LSB +: MOD_W] != modulus));
  assign lock_restart = freq_change || (ref_ok && !ref_prev);

  lock_delay_timer #(
    .CYCLES (LOCK_CYCLES)
  ) u_lock_timer (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .run_i     (synth_mode && ref_ok),
    .restart_i (lock_restart),
    .locked_o  (lock_done)
  );

  // loop acquisition, running and limp; reference loss enters limp
  always_comb begin
    next_state      = state;
    next_reset_hold = device_reset_o;
    if (!synth_mode) begin
      next_state      = clk_running;
      next_reset_hold = 1'b0;
    end else begin
      unique case (state)
        clk_acquire: begin
          if (!ref_ok) begin
            next_state = clk_limp;
          end else if (lock_done) begin
            next_state      = clk_running;
            next_reset_hold = 1'b0;
          end
        end
        clk_running: begin
          if (!ref_ok) begin
            next_state = clk_limp;
          end else if (!lock_done) begin
            next_state = clk_acquire;
          end
        end
        clk_limp: begin
          if (ref_ok) begin
            next_state = clk_acquire;
          end
        end
      endcase
      if (state != clk_limp && next_state == clk_limp && ctl[LOSS_RST_BIT]) begin
        next_reset_hold = 1'b1;
      end
    end
  end

  // sticky events: a new event wins over a same-cycle write-one clear
  always_comb begin
    events = '0;
    events[IRQ_LOCK_BIT] = synth_mode && state == clk_acquire && next_state == clk_running;
    events[IRQ_LIMP_BIT] = state != clk_limp && next_state == clk_limp;
    events[IRQ_LOSS_BIT] = events[IRQ_LIMP_BIT] && ctl[LOSS_RST_BIT];
    next_irq_status = irq_status;
    next_irq_mask   = irq_mask;
    if (wr_status && w_strb[0]) begin
      next_irq_status = irq_status & ~w_data[IRQ_W-1:0];
    end
    if (wr_mask && w_strb[0]) begin
      next_irq_mask = w_data[IRQ_W-1:0];
    end
    next_irq_status   = next_irq_status | events;
    next_written_once = written_once || wr_ctl;
    next_synth_mode   = synth_mode;
  end

  // frequency factors: sys = 4(Y+1)2^(2W+X), vco = sys * (X ? 2 : 4)
  always_comb begin
    divide_by     = 7'({1'b0, modulus} + 7'h01);
    sys_shift     = 3'(3'h2 + {1'b0, gain, 1'b0} + {2'h0, prescale});
    vco_shift     = 3'(3'h4 + {1'b0, gain, 1'b0});
    next_sys_mult = 12'({5'h00, divide_by} << sys_shift);
    next_vco_mult = 13'({6'h00, divide_by} << vco_shift);
    if (!synth_mode) begin
      next_sys_mult = 12'h000;
      next_vco_mult = 13'h0000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      synth_mode          <= pin_level[0];
      ctl                 <= CTL_RESET;
      written_once        <= 1'b0;
      irq_status          <= IRQ_RESET;
      irq_mask            <= IRQ_RESET;
      state               <= clk_acquire;
      device_reset_o      <= 1'b1;
      ref_prev            <= 1'b1;
      system_multiplier_o <= 12'h000;
      vco_multiplier_o    <= 13'h0000;
    end else begin
      synth_mode          <= next_synth_mode;
      ctl                 <= next_ctl;
      written_once        <= next_written_once;
      irq_status          <= next_irq_status;
      irq_mask            <= next_irq_mask;
      state               <= next_state;
      device_reset_o      <= next_reset_hold;
      ref_prev            <= ref_ok;
      system_multiplier_o <= next_sys_mult;
      vco_multiplier_o    <= next_vco_mult;
    end
  end

  // all synthesizer controls except the bus clock divide select are masked while the external clock is used
  assign stop_now                  = low_power_stop_instr_i;
  assign synth_enable_o            = synth_mode;
  assign gain_o                    = synth_mode && gain;
  assign prescale_o                = synth_mode && prescale;
  assign feedback_modulus_o        = synth_mode ? modulus : '0;
  assign bus_clock_divide_select_o = ctl[DIVIDE_BIT];
  // limp keeps the oscillator alive on its base control voltage
  assign oscillator_run_o = synth_mode && !(stop_now && !ctl[STOP_MOD_BIT]);
  assign module_clock_from_vco_o = synth_mode && (!stop_now || ctl[STOP_MOD_BIT]);
  assign clock_output_pin_enable_o = !stop_now || !synth_mode || ctl[STOP_OUT_BIT];
  assign irq_o = |(irq_status & irq_mask);

endmodule : system_clock_synth_control

// ===== tb/ref_source_model.sv
`timescale 1ns/10ps
// far side: reference source and board strap
module ref_source_model (
  input  wire logic clock_i,
  input  wire logic strap_req_i,
  input  wire logic present_req_i,
  output logic      clock_source_strap_o = 1'b1,
  output logic      reference_present_o = 1'b1
);
  // levels move just after an edge, never mid-cycle
  always @(posedge clock_i) begin
    clock_source_strap_o <= strap_req_i;
    reference_present_o  <= present_req_i;
  end
endmodule : ref_source_model

// ===== tb/system_clock_synth_control_checker.sv
`timescale 1ns/10ps
module system_clock_synth_control_checker
  import clock_synth_pkg::*;
#(
  parameter int unsigned LOCK_CYCLES = 20
) (
  input wire logic             clock_i,
  input wire logic             rst_i,
  input wire logic [11:0]      s_axi_araddr_i,
  input wire logic [2:0]       s_axi_arprot_i,
  input wire logic             s_axi_arvalid_i,
  input wire logic             s_axi_arready_o,
  input wire logic [31:0]      s_axi_rdata_o,
  input wire logic [1:0]       s_axi_rresp_o,
  input wire logic             s_axi_rvalid_o,
  input wire logic             s_axi_rready_i,
  input wire logic             low_power_stop_instr_i,
  input wire logic             device_reset_o,
  input wire logic             synth_enable_o,
  input wire logic             gain_o,
  input wire logic             prescale_o,
  input wire logic [MOD_W-1:0] feedback_modulus_o,
  input wire logic [11:0]      system_multiplier_o,
  input wire logic [12:0]      vco_multiplier_o,
  input wire logic             oscillator_run_o,
  input wire logic             module_clock_from_vco_o,
  input wire logic             clock_output_pin_enable_o
);
  localparam int LO = LOCK_CYCLES;
  localparam int HI = LOCK_CYCLES + 4;
  logic [7:0] up_cnt;
  logic [7:0] next_up_cnt;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // cycles since release; saturates so it never wraps under LO
  always_comb begin
    next_up_cnt = rst_i ? 8'h00 : up_cnt + 8'(up_cnt != 8'hFF);
  end
  always_ff @(posedge clock_i) begin
    up_cnt <= next_up_cnt;
  end
  property p_sys_mult;
    synth_enable_o |=> system_multiplier_o == ((12'($past(feedback_modulus_o)) + 12'h001)
      << (2 * $past(gain_o) + $past(prescale_o) + 2));
  endproperty
  a_sys_mult: assert property (p_sys_mult) else $error("system multiplier off");
  property p_vco_mult;
    synth_enable_o |=> vco_multiplier_o == ((13'($past(feedback_modulus_o)) + 13'h0001)
      << (4 + 2 * $past(gain_o)));
  endproperty
  a_vco_mult: assert property (p_vco_mult) else $error("vco multiplier off");
  property p_ext_off;
    !synth_enable_o |-> !(gain_o | prescale_o | oscillator_run_o | module_clock_from_vco_o)
      && feedback_modulus_o == '0 && system_multiplier_o == 12'h000;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("external mode not inert");
  property p_run;
    !low_power_stop_instr_i |-> clock_output_pin_enable_o
      && oscillator_run_o == synth_enable_o && module_clock_from_vco_o == synth_enable_o;
  endproperty
  a_run: assert property (p_run) else $error("running clocks wrong");
  property p_hold;
    synth_enable_o && up_cnt < LO |-> device_reset_o;
  endproperty
  a_hold: assert property (p_hold) else $error("reset released before lock");
  property p_lock_release;
    $fell(rst_i) && synth_enable_o |-> ##[LO:HI] !device_reset_o;
  endproperty
  a_lock_release: assert property (p_lock_release) else $error("reset not released");
  property p_ext_release;
    $fell(rst_i) && !synth_enable_o |-> ##[0:2] !device_reset_o;
  endproperty
  a_ext_release: assert property (p_ext_release) else $error("ext reset stuck");
  property p_rd_user;
    s_axi_arvalid_i && s_axi_arready_o && !s_axi_arprot_i[0] && s_axi_araddr_i == CTL_OFFSET
      |=> s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000;
  endproperty
  a_rd_user: assert property (p_rd_user) else $error("user read reached control");
  property p_rd_ext;
    s_axi_arvalid_i && s_axi_arready_o && s_axi_arprot_i[0] && s_axi_araddr_i == CTL_OFFSET
      && !synth_enable_o |=> s_axi_rdata_o[LOCK_BIT] && s_axi_rdata_o[6:5] == 2'h0;
  endproperty
  a_rd_ext: assert property (p_rd_ext) else $error("external lock flag wrong");
  property p_rhold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule : system_clock_synth_control_checker

bind system_clock_synth_control system_clock_synth_control_checker #(
  .LOCK_CYCLES(LOCK_CYCLES)
) u_checker (
  .clock_i, .rst_i, .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .low_power_stop_instr_i,
  .device_reset_o, .synth_enable_o, .gain_o, .prescale_o, .feedback_modulus_o,
  .system_multiplier_o, .vco_multiplier_o, .oscillator_run_o, .module_clock_from_vco_o,
  .clock_output_pin_enable_o
);

// ===== tb/tb_system_clock_synth_control.sv
`timescale 1ns/10ps
module tb_system_clock_synth_control;
  import clock_synth_pkg::*;
  localparam int unsigned LC = 20;
  logic             clock_i = 1'b0, rst_i = 1'b1, strap_req = 1'b1, present_req = 1'b1;
  logic [11:0]      s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
  logic [2:0]       s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
  logic [31:0]      s_axi_wdata_i = 32'h0000_0000;
  logic [3:0]       s_axi_wstrb_i = 4'h0;
  logic             s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic             s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, low_power_stop_instr_i = 1'b0;
  logic             clock_source_strap_i, reference_present_i, s_axi_awready_o;
  logic             s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]       s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0]      s_axi_rdata_o;
  logic             device_reset_o, synth_enable_o, gain_o, prescale_o, irq_o;
  logic             bus_clock_divide_select_o, oscillator_run_o;
  logic             module_clock_from_vco_o, clock_output_pin_enable_o;
  logic [MOD_W-1:0] feedback_modulus_o;
  logic [11:0]      system_multiplier_o;
  logic [12:0]      vco_multiplier_o;
  int               n_fail = 0;
  int               samples_checked = 0;
  logic [15:0]      freq_tbl [4] = '{16'h0000, 16'h4100, 16'h8200, 16'hFF00};

  always #25 clock_i = ~clock_i;

  system_clock_synth_control #(.LOCK_CYCLES(LC)) dut (
    .clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awprot_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arprot_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .clock_source_strap_i, .reference_present_i, .low_power_stop_instr_i, .device_reset_o,
    .synth_enable_o, .gain_o, .prescale_o, .feedback_modulus_o, .system_multiplier_o,
    .vco_multiplier_o, .bus_clock_divide_select_o, .oscillator_run_o,
    .module_clock_from_vco_o, .clock_output_pin_enable_o, .irq_o
  );
  ref_source_model u_ref (
    .clock_i, .strap_req_i(strap_req), .present_req_i(present_req),
    .clock_source_strap_o(clock_source_strap_i), .reference_present_o(reference_present_i)
  );

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // address and data offered together, each dropped once taken; only the watchdog ends a wait
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic p = 1'b1,
                    input logic [1:0] er = RESP_OKAY);
    {s_axi_awaddr_i, s_axi_awprot_i, s_axi_wdata_i} <= {a, 2'b00, p, 16'h0000, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_wstrb_i} <= {3'b111, 4'h3};
    do begin
      @(posedge clock_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    chk("bresp", 32'(er), 32'(s_axi_bresp_o));
    s_axi_bready_i <= 1'b0;
    @(posedge clock_i);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [31:0] m = 32'hFFFF_FFFF, input logic p = 1'b1,
                    input logic [1:0] er = RESP_OKAY);
    {s_axi_araddr_i, s_axi_arprot_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'b00, p, 2'b11};
    do begin
      @(posedge clock_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    chk("rdata", ed & m, s_axi_rdata_o & m);
    chk("rresp", 32'(er), 32'(s_axi_rresp_o));
    s_axi_rready_i <= 1'b0;
    @(posedge clock_i);
  endtask : rd

  task automatic reset_dut(input logic strap);
    {strap_req, rst_i} <= {strap, 1'b1};
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
  endtask : reset_dut

  task automatic wait_run();
    do @(posedge clock_i); while (device_reset_o !== 1'b0);
  endtask : wait_run

  task automatic outs(input logic [2:0] e);
    repeat (2) @(posedge clock_i);
    chk("clocks", 32'(e), 32'({oscillator_run_o, module_clock_from_vco_o,
        clock_output_pin_enable_o}));
  endtask : outs

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // watchdog: the tests need well under 2000 cycles
  initial begin
    #1000000;
    n_fail++;
    final_report();
  end

  initial begin
    int w, x, y;
    reset_dut(1'b1);
    @(posedge clock_i);
    chk("hold", 1, device_reset_o);
    chk("synth", 1, synth_enable_o);
    wait_run();
    chk("sysmul", 32'h100, 32'(system_multiplier_o));
    rd(CTL_OFFSET, 32'h3F00);
    $display("test reset done");
    wr(CTL_OFFSET, 16'h0000, 1'b0, RESP_SLVERR);
    rd(CTL_OFFSET, 32'h0, 32'hFFFF_FFFF, 1'b0, RESP_SLVERR);
    rd(CTL_OFFSET, 32'h3F00);
    rd(12'h00C, 32'h0, 32'hFFFF_FFFF, 1'b1, RESP_SLVERR);
    wr(12'h00C, 16'h0001, 1'b1, RESP_SLVERR);
    $display("test access done");
    // legal frequency settings only
    foreach (freq_tbl[i]) begin
      w = freq_tbl[i][15];
      x = freq_tbl[i][14];
      y = freq_tbl[i][13:8];
      wr(CTL_OFFSET, freq_tbl[i]);
      repeat (2) @(posedge clock_i);
      chk("sysmul", 32'((4 * (y + 1)) << (2 * w + x)), 32'(system_multiplier_o));
      chk("vcomul", 32'((y + 1) << (4 + 2 * w)), 32'(vco_multiplier_o));
      chk("fields", 32'({w[0], x[0], y[5:0]}), 32'({gain_o, prescale_o,
          feedback_modulus_o}));
    end
    $display("test frequency done");
    wr(IRQ_STATUS_OFFSET, 16'h0007);
    wr(CTL_OFFSET, 16'h0100);
    rd(CTL_OFFSET, 32'h0100);
    repeat (LC + 5) @(posedge clock_i);
    rd(CTL_OFFSET, 32'h0108);
    rd(IRQ_STATUS_OFFSET, 32'h1);
    chk("irq", 0, irq_o);
    wr(IRQ_MASK_OFFSET, 16'h0001);
    chk("irq", 1, irq_o);
    wr(IRQ_STATUS_OFFSET, 16'h0001);
    chk("irq", 0, irq_o);
    wr(CTL_OFFSET, 16'h4100);
    rd(CTL_OFFSET, 32'h4108);
    wr(CTL_OFFSET, 16'hC100);
    rd(CTL_OFFSET, 32'hC100);
    repeat (LC + 5) @(posedge clock_i);
    $display("test lock done");
    present_req <= 1'b0;
    repeat (8) @(posedge clock_i);
    rd(CTL_OFFSET, 32'h10, 32'h10);
    chk("osc", 1, oscillator_run_o);
    chk("devrst", 0, device_reset_o);
    rd(IRQ_STATUS_OFFSET, 32'h2, 32'h2);
    present_req <= 1'b1;
    repeat (LC + 8) @(posedge clock_i);
    wr(CTL_OFFSET, 16'hC104);
    repeat (LC + 8) @(posedge clock_i);
    present_req <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk("devrst", 1, device_reset_o);
    present_req <= 1'b1;
    wait_run();
    chk("devrst", 0, device_reset_o);
    rd(IRQ_STATUS_OFFSET, 32'h4, 32'h4);
    $display("test limp done");
    wr(CTL_OFFSET, 16'hC100);
    low_power_stop_instr_i <= 1'b1;
    outs(3'b000);
    wr(CTL_OFFSET, 16'hC183);
    outs(3'b111);
    chk("bus_clock_divide_select", 1, bus_clock_divide_select_o);
    low_power_stop_instr_i <= 1'b0;
    $display("test stop done");
    reset_dut(1'b0);
    wait_run();
    chk("synth", 0, synth_enable_o);
    wr(CTL_OFFSET, 16'hFF00);
    repeat (2) @(posedge clock_i);
    chk("sysmul", 0, 32'(system_multiplier_o));
    rd(CTL_OFFSET, 32'hFF08, 32'hFF78);
    present_req <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk("devrst", 0, device_reset_o);
    rd(CTL_OFFSET, 32'h0, 32'h10);
    $display("test external done");
    final_report();
  end
endmodule : tb_system_clock_synth_control
